/* hdl/rsw_writeback.sv */
// Receive descriptor status writeback with register slave
`timescale 1ns/10ps
`default_nettype none
module rsw_writeback
   import rsw_pkg::*;
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // Avalon-MM slave
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // Descriptor fetch result
   input wire logic desc_valid,
   input wire logic [31:0] desc_word,
   input wire logic [10:0] buf1_size,
   input wire logic [10:0] buf2_size,
   input wire logic next_owned,
   // Frame end report
   input wire logic seg_done,
   input wire logic frame_end,
   input wire logic [13:0] byte_count,
   input wire logic crc_bad,
   input wire logic rx_err,
   input wire logic late_col,
   input wire logic mismatch,
   input wire logic mcast,
   // Status word writeback
   output logic wb_valid,
   output logic [31:0] wb_word,
   output logic start_buf2,
   output logic suspended,
   output logic drop_frame,
   output logic irq
);
   import rsw_pkg::*;
   typedef enum logic [1:0] {RSW_IDLE, RSW_OWNED, RSW_SUSP} rsw_state_e;

   ////////////////////////////////////////////////////////////////////
   // Registers
   rsw_state_e state;
   logic keep_errored;
   logic vlan_en;
   logic [RSW_EV_W-1:0] ev_stat;
   logic [RSW_EV_W-1:0] ev_mask;
   logic [31:0] last_word;
   logic in_frame;
   logic start_seen;
   logic ack;

   ////////////////////////////////////////////////////////////////////
   // Status assembly
   wire own_ok = desc_valid & desc_word[RSW_OWN_BIT];
   wire final_seg = frame_end | (seg_done & ~next_owned);
   wire truncated = seg_done & ~frame_end & ~next_owned;
   wire first_seg = ~in_frame & start_seen;
   wire [31:0] built;
   wire start_here;
   wire start_b2;
   rsw_status_build u_build (
      .byte_count(byte_count),
      .final_seg(final_seg),
      .first_seg(first_seg),
      .truncated(truncated),
      .crc_bad(crc_bad),
      .rx_err(rx_err),
      .late_col(late_col),
      .mismatch(mismatch),
      .mcast(mcast),
      .vlan_en(vlan_en),
      .word(built)
   );
   rsw_first_place u_place (
      .buf1_size(buf1_size),
      .buf2_size(buf2_size),
      .start_here(start_here),
      .start_buf2(start_b2)
   );
   wire closing = (state == RSW_OWNED) & (seg_done | frame_end);
   wire is_runt = built[RSW_RUNT_BIT];
   wire drop_now = closing & frame_end & is_runt & ~keep_errored;

   ////////////////////////////////////////////////////////////////////
   // Descriptor state machine
   rsw_state_e next_state;
   always_comb begin
      next_state = state;
      case (state)
         RSW_IDLE: begin
            if (desc_valid)
               next_state = own_ok ? RSW_OWNED : RSW_SUSP;
         end
         RSW_OWNED: begin
            if (closing)
               next_state = RSW_IDLE;
         end
         RSW_SUSP: begin
            if (own_ok)
               next_state = RSW_OWNED;
         end
         default: next_state = RSW_IDLE;
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (rst)
         state <= RSW_IDLE;
      else
         state <= next_state;
   end

   // Tracks whether a frame is already underway across descriptors
   always_ff @(posedge core_clk) begin
      if (rst)
         in_frame <= 1'b0;
      else if (closing)
         in_frame <= ~final_seg & (in_frame | start_seen);
   end

   ////////////////////////////////////////////////////////////////////
   // Frame start placement
   // Descriptor with both buffers empty cannot hold the frame start
   always_ff @(posedge core_clk) begin
      if (rst)
         start_seen <= 1'b0;
      else if (desc_valid)
         start_seen <= start_here;
   end

   ////////////////////////////////////////////////////////////////////
   // Writeback outputs
   always_ff @(posedge core_clk) begin
      if (rst)
         wb_valid <= 1'b0;
      else
         wb_valid <= closing & ~drop_now;
   end

   always_ff @(posedge core_clk) begin
      if (rst)
         wb_word <= 32'h00000000;
      else if (closing)
         wb_word <= built;
   end

   always_ff @(posedge core_clk) begin
      if (rst)
         drop_frame <= 1'b0;
      else
         drop_frame <= drop_now;
   end

   always_ff @(posedge core_clk) begin
      if (rst)
         start_buf2 <= 1'b0;
      else if (desc_valid)
         start_buf2 <= start_b2;
   end

   always_ff @(posedge core_clk) begin
      if (rst)
         suspended <= 1'b0;
      else
         suspended <= (next_state == RSW_SUSP);
   end

   ////////////////////////////////////////////////////////////////////
   // Events
   wire [RSW_EV_W-1:0] ev_in;
   assign ev_in[RSW_EV_DONE] = closing & ~drop_now;
   assign ev_in[RSW_EV_SUSP] = (state != RSW_SUSP) & (next_state == RSW_SUSP);
   assign ev_in[RSW_EV_DROP] = drop_now;

   ////////////////////////////////////////////////////////////////////
   // Avalon slave, one wait cycle per access
   // Register offset match
   function automatic logic reg_hit(input logic [3:0] addr, input logic [3:0] offset);
      return addr == offset;
   endfunction

   // Request seen first, accepted at the edge with waitrequest low
   wire req = (avs_read | avs_write) & ~ack;
   wire taken = (avs_read | avs_write) & ack;
   wire wr_ctrl = taken & avs_write & reg_hit(avs_address, RSW_REG_CTRL);
   wire wr_mask = taken & avs_write & reg_hit(avs_address, RSW_REG_MASK);
   wire rd_stat = req & avs_read & reg_hit(avs_address, RSW_REG_STAT);

   // Register read views
   wire [31:0] ctrl_view = {30'h00000000, vlan_en, keep_errored};
   wire [31:0] stat_view = {29'h00000000, ev_stat};
   wire [31:0] mask_view = {29'h00000000, ev_mask};
   logic [31:0] rd_mux;
   always_comb begin
      case (avs_address)
         RSW_REG_CTRL: rd_mux = ctrl_view;
         RSW_REG_STAT: rd_mux = stat_view;
         RSW_REG_MASK: rd_mux = mask_view;
         RSW_REG_LAST: rd_mux = last_word;
         default: rd_mux = 32'h00000000;
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (rst)
         ack <= 1'b0;
      else
         ack <= req;
   end

   always_ff @(posedge core_clk) begin
      if (rst)
         avs_waitrequest <= 1'b1;
      else
         avs_waitrequest <= ~req;
   end

   always_ff @(posedge core_clk) begin
      if (rst)
         avs_readdata <= 32'h00000000;
      else if (req && avs_read)
         avs_readdata <= rd_mux;
   end

   ////////////////////////////////////////////////////////////////////
   // Control and mask registers
   always_ff @(posedge core_clk) begin
      if (rst)
         keep_errored <= 1'b0;
      else if (wr_ctrl)
         keep_errored <= avs_writedata[RSW_CTRL_KEEP_BIT];
   end

   always_ff @(posedge core_clk) begin
      if (rst)
         vlan_en <= 1'b0;
      else if (wr_ctrl)
         vlan_en <= avs_writedata[RSW_CTRL_VLAN_BIT];
   end

   always_ff @(posedge core_clk) begin
      if (rst)
         ev_mask <= 3'h0;
      else if (wr_mask)
         ev_mask <= avs_writedata[RSW_EV_W-1:0];
   end

   ////////////////////////////////////////////////////////////////////
   // Sticky event bits, set wins over read-clear
   wire [RSW_EV_W-1:0] next_ev_stat;
   genvar gi;
   generate
      for (gi = 0; gi < RSW_EV_W; gi++) begin : g_ev
         assign next_ev_stat[gi] = (ev_stat[gi] & ~rd_stat) | ev_in[gi];
      end
   endgenerate

   always_ff @(posedge core_clk) begin
      if (rst)
         ev_stat <= 3'h0;
      else
         ev_stat <= next_ev_stat;
   end

   ////////////////////////////////////////////////////////////////////
   // Last status word
   always_ff @(posedge core_clk) begin
      if (rst)
         last_word <= 32'h00000000;
      else if (closing)
         last_word <= built;
   end

   ////////////////////////////////////////////////////////////////////
   // Interrupt output
   always_ff @(posedge core_clk) begin
      if (rst)
         irq <= 1'b0;
      else
         irq <= |(next_ev_stat & ev_mask);
   end
endmodule
`default_nettype wire

/* hdl/rsw_pkg.sv */
// Package of constants for the receive status writeback block
package rsw_pkg;
   // Status word field positions
   localparam int RSW_OWN_BIT = 31;
   localparam int RSW_CNT_HI = 29;
   localparam int RSW_CNT_LO = 16;
   localparam int RSW_ES_BIT = 15;
   localparam int RSW_TRUNC_BIT = 14;
   localparam int RSW_RSVD_BIT = 13;
   localparam int RSW_MISMATCH_BIT = 12;
   localparam int RSW_RUNT_BIT = 11;
   localparam int RSW_MCAST_BIT = 10;
   localparam int RSW_FIRST_BIT = 9;
   localparam int RSW_FINAL_BIT = 8;
   localparam int RSW_OVERSIZE_BIT = 7;
   localparam int RSW_LATE_COL_BIT = 6;
   localparam int RSW_CRC_BIT = 1;
   localparam int RSW_CNT_W = 14;
   // Frame size limits in bytes
   localparam logic [RSW_CNT_W-1:0] RSW_COL_WINDOW = 14'h0040;
   localparam logic [RSW_CNT_W-1:0] RSW_MAX_PLAIN = 14'h05EE;
   localparam logic [RSW_CNT_W-1:0] RSW_MAX_VLAN = 14'h05F2;
   localparam logic [RSW_CNT_W-1:0] RSW_ONE = 14'h0001;
   localparam logic [RSW_CNT_W-1:0] RSW_ZERO_LEN = 14'h0000;
   // Register byte offsets
   localparam logic [3:0] RSW_REG_CTRL = 4'h0;
   localparam logic [3:0] RSW_REG_STAT = 4'h4;
   localparam logic [3:0] RSW_REG_MASK = 4'h8;
   localparam logic [3:0] RSW_REG_LAST = 4'hC;
   // Control register field positions
   localparam int RSW_CTRL_KEEP_BIT = 0;
   localparam int RSW_CTRL_VLAN_BIT = 1;
   // Interrupt event bits
   localparam int RSW_EV_W = 3;
   localparam int RSW_EV_DONE = 0;
   localparam int RSW_EV_SUSP = 1;
   localparam int RSW_EV_DROP = 2;
endpackage

/* hdl/rsw_status_build.sv */
// Combinational assembly of the receive status word
`timescale 1ns/10ps
`default_nettype none
module rsw_status_build
   import rsw_pkg::*;
(
   // Frame facts
   input wire logic [13:0] byte_count,
   input wire logic final_seg,
   input wire logic first_seg,
   input wire logic truncated,
   input wire logic crc_bad,
   input wire logic rx_err,
   input wire logic late_col,
   input wire logic mismatch,
   input wire logic mcast,
   input wire logic vlan_en,
   // Assembled word, ownership cleared
   output logic [31:0] word
);
   import rsw_pkg::*;
   wire trunc_flag = truncated & final_seg;
   wire runt = final_seg & (byte_count < RSW_COL_WINDOW);
   wire oversize = final_seg & (byte_count > (vlan_en ? RSW_MAX_VLAN : RSW_MAX_PLAIN));
   wire crc_flag = crc_bad | rx_err;
   wire es = crc_flag | late_col | oversize | runt | trunc_flag;
   wire [13:0] cnt = (final_seg & ~trunc_flag) ? byte_count : RSW_ZERO_LEN;
   always_comb begin
      word = 32'h00000000;
      word[RSW_CNT_HI:RSW_CNT_LO] = cnt;
      word[RSW_ES_BIT] = es;
      word[RSW_TRUNC_BIT] = trunc_flag;
      word[RSW_RSVD_BIT] = 1'b0;
      word[RSW_MISMATCH_BIT] = mismatch;
      word[RSW_RUNT_BIT] = runt;
      word[RSW_MCAST_BIT] = mcast;
      word[RSW_FIRST_BIT] = first_seg;
      word[RSW_FINAL_BIT] = final_seg;
      word[RSW_OVERSIZE_BIT] = oversize;
      word[RSW_LATE_COL_BIT] = late_col;
      word[RSW_CRC_BIT] = crc_flag;
      word[RSW_OWN_BIT] = 1'b0;
   end
endmodule
`default_nettype wire

/* hdl/rsw_first_place.sv */
// Placement of frame start past zero-sized buffers
`timescale 1ns/10ps
`default_nettype none
module rsw_first_place
   import rsw_pkg::*;
(
   // Buffer sizes of the current descriptor
   input wire logic [10:0] buf1_size,
   input wire logic [10:0] buf2_size,
   // Start lands here, and in which buffer
   output logic start_here,
   output logic start_buf2
);
   import rsw_pkg::*;
   wire b1_zero = (buf1_size == 11'h000);
   wire b2_zero = (buf2_size == 11'h000);
   assign start_here = ~(b1_zero & b2_zero);
   assign start_buf2 = b1_zero & ~b2_zero;
endmodule
`default_nettype wire

/* bench/rsw_host_model.sv */
// Host memory model holding the last written-back status word
`timescale 1ns/10ps
`default_nettype none
module rsw_host_model (
   // Clock and writeback
   input wire logic core_clk,
   input wire logic wb_valid,
   input wire logic [31:0] wb_word,
   // Host view
   output var logic [31:0] host_word,
   output var logic [7:0] n_wb
);
   initial n_wb = 8'h00;
   always @(posedge core_clk) begin
      if (wb_valid) begin
         host_word <= wb_word & 32'hFFFFDFFF;
         n_wb <= n_wb + 8'h01;
      end
   end
endmodule
`default_nettype wire

/* bench/rsw_writeback_properties.sv */
// Assertion checker for the status writeback block
`timescale 1ns/10ps
`default_nettype none
module rsw_wb_chk (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // Fetch and frame inputs
   input wire logic desc_valid,
   input wire logic [31:0] desc_word,
   input wire logic seg_done,
   input wire logic frame_end,
   input wire logic next_owned,
   input wire logic [13:0] byte_count,
   input wire logic crc_bad,
   input wire logic rx_err,
   input wire logic late_col,
   input wire logic mismatch,
   input wire logic mcast,
   // Writeback outputs
   input wire logic wb_valid,
   input wire logic [31:0] wb_word,
   input wire logic suspended,
   input wire logic drop_frame
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   property p_own;
      wb_valid |-> !wb_word[31];
   endproperty
   a_own: assert property (p_own) else $error("owner set");
   property p_rsvd;
      wb_valid |-> !wb_word[13];
   endproperty
   a_rsvd: assert property (p_rsvd) else $error("reserved set");
   property p_es;
      wb_valid |-> wb_word[15] == |{wb_word[1], wb_word[6], wb_word[7], wb_word[11], wb_word[14]};
   endproperty
   a_es: assert property (p_es) else $error("summary wrong");
   property p_cntz;
      wb_valid && (!wb_word[8] || wb_word[14]) |-> wb_word[29:16] == 14'h0000;
   endproperty
   a_cntz: assert property (p_cntz) else $error("count filled");
   property p_trunc;
      seg_done && !frame_end && !next_owned |=> wb_valid && wb_word[14] && wb_word[8];
   endproperty
   a_trunc: assert property (p_trunc) else $error("no truncation");
   property p_end;
      frame_end |=> drop_frame || wb_valid && wb_word[8] && wb_word[29:16] == $past(byte_count);
   endproperty
   a_end: assert property (p_end) else $error("bad close");
   property p_flag;
      frame_end |=> !wb_valid || wb_word[1] == ($past(crc_bad) | $past(rx_err))
         && wb_word[6] == $past(late_col);
   endproperty
   a_flag: assert property (p_flag) else $error("flag wrong");
   property p_kind;
      frame_end |=> !wb_valid || wb_word[10] == $past(mcast)
         && wb_word[12] == $past(mismatch);
   endproperty
   a_kind: assert property (p_kind) else $error("kind wrong");
   property p_susp;
      desc_valid && !desc_word[31] |-> ##[1:2] suspended;
   endproperty
   a_susp: assert property (p_susp) else $error("no suspend");
endmodule
bind rsw_writeback rsw_wb_chk i_chk (.core_clk, .rst, .desc_valid, .desc_word, .seg_done,
   .frame_end, .next_owned, .byte_count, .crc_bad, .rx_err, .late_col, .mismatch, .mcast,
   .wb_valid, .wb_word, .suspended, .drop_frame);
`default_nettype wire

/* bench/rx_descriptor_status_writeback_bench.sv */
// Self-checking bench for the status writeback block
`timescale 1ns/10ps
`default_nettype none
module rx_descriptor_status_writeback_bench;
   import rsw_pkg::*;
   logic core_clk = 1'h0, rst = 1'h1, avs_read = 1'h0, avs_write = 1'h0, desc_valid = 1'h0;
   logic next_owned = 1'h0, seg_done = 1'h0, frame_end = 1'h0, dr;
   logic crc_bad = 1'h0, rx_err = 1'h0, late_col = 1'h0, mismatch = 1'h0, mcast = 1'h0;
   logic [3:0] avs_address = 4'h0;
   logic [31:0] avs_writedata = 32'h0, desc_word = 32'h0, avs_readdata, wb_word, host_word, q, r;
   logic [10:0] buf1_size = 11'h0, buf2_size = 11'h0, b2sz = 11'h100;
   logic [13:0] byte_count = 14'h0;
   logic avs_waitrequest, wb_valid, start_buf2, suspended, drop_frame, irq;
   logic [7:0] n_wb;
   int err_total = 0, n_tests = 0, cyc = 0;
   logic [13:0] bcs [10] = '{14'h0064, 14'h0064, 14'h0064, 14'h0064, 14'h0064, 14'h003F,
      14'h0040, 14'h05EF, 14'h05F2, 14'h05F3};
   logic [4:0] fls [10] = '{5'h01, 5'h10, 5'h08, 5'h04, 5'h02, 5'h00, 5'h00, 5'h00, 5'h00, 5'h00};
   always #2 core_clk = !core_clk;
   rsw_writeback i_dut (.core_clk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
      .avs_readdata, .avs_waitrequest, .desc_valid, .desc_word, .buf1_size, .buf2_size,
      .next_owned, .seg_done, .frame_end, .byte_count, .crc_bad, .rx_err, .late_col,
      .mismatch, .mcast, .wb_valid, .wb_word, .start_buf2, .suspended, .drop_frame, .irq);
   rsw_host_model i_host (.core_clk, .wb_valid, .wb_word, .host_word, .n_wb);
   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] ew(input logic [13:0] bc, input logic [1:0] fl,
      input logic t, vl, input logic [4:0] f);
      logic [31:0] w;
      w = 32'h0;
      w[29:16] = (fl[0] && !t) ? bc : 14'h0;
      w[14] = t;
      w[12] = f[1];
      w[11] = fl[0] && !t && bc < 14'h0040;
      w[10] = f[0];
      w[9:8] = fl;
      w[7] = fl[0] && bc > (vl ? 14'h05F2 : 14'h05EE);
      w[6] = f[2];
      w[1] = f[4] | f[3];
      w[15] = w[1] | w[6] | w[7] | w[11] | w[14];
      return w;
   endfunction
   task automatic chk(input logic [31:0] g, e);
      n_tests++;
      if (g !== e) begin
         err_total++;
         $display("mismatch %0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
      @(posedge core_clk);
      avs_address <= a;
      avs_write <= w;
      avs_read <= !w;
      avs_writedata <= d;
      do @(posedge core_clk); while (avs_waitrequest !== 1'h0);
      q = avs_readdata;
      avs_write <= 1'h0;
      avs_read <= 1'h0;
   endtask
   task automatic dsc(input logic own, input logic [10:0] b1);
      @(posedge core_clk);
      desc_valid <= 1'h1;
      desc_word <= {own, 31'h0};
      buf1_size <= b1;
      buf2_size <= b2sz;
      @(posedge core_clk);
      desc_valid <= 1'h0;
   endtask
   task automatic frm(input logic [10:0] b1, input logic e, input logic [13:0] bc,
      input logic [4:0] f, input logic nx);
      dsc(1'h1, b1);
      @(posedge core_clk);
      {crc_bad, rx_err, late_col, mismatch, mcast} <= f;
      byte_count <= bc;
      next_owned <= nx;
      frame_end <= e;
      seg_done <= !e;
      @(posedge core_clk);
      frame_end <= 1'h0;
      seg_done <= 1'h0;
      do @(posedge core_clk); while (!wb_valid && !drop_frame);
      r = wb_word;
      dr = drop_frame;
   endtask
   task automatic ev(input logic v);
      repeat (2) @(posedge core_clk);
      chk({31'h0, irq}, {31'h0, v});
   endtask
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 2000) begin
         err_total++;
         report_and_stop();
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (2) @(posedge core_clk);
      rst <= 1'h0;
      bus(1'h0, RSW_REG_CTRL, 32'h0);
      chk(q, 32'h0);
      bus(1'h1, 4'h1, 32'hFFFFFFFF);
      bus(1'h0, 4'h1, 32'h0);
      chk(q, 32'h0);
      bus(1'h1, RSW_REG_MASK, 32'h7);
      for (int i = 0; i < 10; i++) begin
         bus(1'h1, RSW_REG_CTRL, {30'h0, i > 7, 1'h1});
         frm(11'h100, 1'h1, bcs[i], fls[i], 1'h1);
         chk(r, ew(bcs[i], 2'h3, 1'h0, i > 7, fls[i]));
      end
      ev(1'h1);
      bus(1'h0, RSW_REG_STAT, 32'h0);
      chk(q, 32'h1);
      ev(1'h0);
      bus(1'h1, RSW_REG_CTRL, 32'h0);
      frm(11'h100, 1'h1, 14'h003F, 5'h0, 1'h1);
      chk({31'h0, dr}, 32'h1);
      bus(1'h1, RSW_REG_MASK, 32'h0);
      frm(11'h100, 1'h1, 14'h0064, 5'h0, 1'h1);
      ev(1'h0);
      bus(1'h1, RSW_REG_MASK, 32'h7);
      ev(1'h1);
      bus(1'h0, RSW_REG_STAT, 32'h0);
      chk(q, 32'h5);
      b2sz = 11'h000;
      frm(11'h0, 1'h0, 14'h0, 5'h0, 1'h1);
      chk({31'h0, start_buf2}, 32'h0);
      chk(r, ew(14'h0, 2'h0, 1'h0, 1'h0, 5'h0));
      b2sz = 11'h100;
      frm(11'h0, 1'h0, 14'h0, 5'h0, 1'h1);
      chk({31'h0, start_buf2}, 32'h1);
      chk(r, ew(14'h0, 2'h2, 1'h0, 1'h0, 5'h0));
      frm(11'h100, 1'h1, 14'h012C, 5'h0, 1'h1);
      chk(r, ew(14'h012C, 2'h1, 1'h0, 1'h0, 5'h0));
      frm(11'h100, 1'h0, 14'h00C8, 5'h0, 1'h0);
      chk(r, ew(14'h00C8, 2'h3, 1'h1, 1'h0, 5'h0));
      dsc(1'h0, 11'h100);
      ev(1'h1);
      chk({31'h0, suspended}, 32'h1);
      chk({24'h0, n_wb}, 32'h0F);
      chk(host_word, ew(14'h00C8, 2'h3, 1'h1, 1'h0, 5'h0));
      report_and_stop();
   end
endmodule
`default_nettype wire
